//--- verilog/buck_fault_count_softstart.sv
/*
  overcurrent fault counter, short-circuit trip, multiplier calibration and soft-start
  sequencing of a synchronous buck controller.
  assumes comparator results and analog level detects arrive as asynchronous pins;
  cycle_start is a one-cycle pulse from the switching oscillator in the sys_clk domain.
*/
`timescale 1ns/1ps
module buck_fault_count_softstart #(
  parameter int CAL_LEN = buck_fault_pkg::CAL_CYCLES,
  parameter int BLANK_LEN = buck_fault_pkg::BLANK_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // power-up conditions (pins)
  input wire logic enable_pin,
  input wire logic input_undervoltage_lockout,
  input wire logic gate_supply_rail_ok,
  // switching cycle and pwm request
  input wire logic cycle_start,
  input wire logic pwm_high_req,
  // comparator results (pins)
  input wire logic low_over_limit,
  input wire logic low_over_limit_x15,
  input wire logic high_over_mult_x3,
  input wire logic high_over_mult_x7,
  input wire logic high_over_mult_x15,
  // resistor sense on low-side pin during calibration (pins)
  input wire logic [1:0] res_sense,
  // soft-start node level detects (pins)
  input wire logic ss_above_0v3,
  input wire logic ss_above_0v5,
  input wire logic ss_above_0v65,
  input wire logic ss_above_2v5,
  // gate drives
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  // fault and multiplier status
  output logic overcurrent_fault_flag,
  output logic overload_trip,
  output logic short_circuit_trip,
  output logic [3:0] short_multiplier_code,
  output logic [2:0] fault_count,
  // soft-start node controls
  output logic ss_fast_discharge,
  output logic ss_slow_discharge,
  output logic ss_normal_charge,
  output logic ss_boost_charge,
  output logic ss_ref_enable,
  output logic ss_clamp_enable,
  output logic ss_limit_raised
);
  localparam int SYNC_W = 14;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic en_s, input_undervoltage_lockout_s, vbp_ok_s, lo_s, lo15_s, hi3_s, hi7_s, hi15_s;
  logic [1:0] res_s;
  logic ss03_s, ss05_s, ss065_s, ss25_s;

  assign sync_in = {enable_pin, input_undervoltage_lockout, gate_supply_rail_ok,
                    low_over_limit, low_over_limit_x15, high_over_mult_x3,
                    high_over_mult_x7, high_over_mult_x15, res_sense,
                    ss_above_0v3, ss_above_0v5, ss_above_0v65, ss_above_2v5};
  assign {en_s, input_undervoltage_lockout_s, vbp_ok_s, lo_s, lo15_s, hi3_s, hi7_s, hi15_s, res_s,
          ss03_s, ss05_s, ss065_s, ss25_s} = sync_out;

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(sync_in),
    .level_out(sync_out)
  );

  // power good for the sequencer
  logic power_ok;
  assign power_ok = en_s && !input_undervoltage_lockout_s && vbp_ok_s;

  // ---------------- sequencer state ----------------
  buck_fault_pkg::seq_state_type state, next_state;
  logic [15:0] cal_cnt, next_cal_cnt;
  logic [3:0] mult, next_mult;
  logic boost, next_boost;

  // ---------------- counter and gate state ----------------
  logic [2:0] count, next_count;
  logic fault, next_fault;
  logic sc_trip, next_sc_trip;
  logic ol_trip, next_ol_trip;
  logic lo_pending, next_lo_pending;
  logic lo_sampled, next_lo_sampled;
  logic hs_on, next_hs_on;
  logic ls_on, next_ls_on;
  logic [15:0] blank_cnt, next_blank_cnt;
  logic hs_over, ls_over;

  logic run_pwm;
  assign run_pwm = (state == buck_fault_pkg::ST_SS) || (state == buck_fault_pkg::ST_RUN);

  // selected multiplier comparator
  always_comb begin
    case (mult)
      buck_fault_pkg::MULT_LOW: hs_over = hi3_s;
      buck_fault_pkg::MULT_HIGH: hs_over = hi15_s;
      default: hs_over = hi7_s;
    endcase
  end

  // raised limit while node below 2.5 V uses the 1.5x comparator
  assign ls_over = ss25_s ? lo_s : lo15_s;

  always_comb begin
    next_state = state;
    next_cal_cnt = cal_cnt;
    next_mult = mult;
    next_boost = boost;
    if (!power_ok) begin
      next_state = buck_fault_pkg::ST_OFF;
      next_cal_cnt = '0;
      next_boost = 1'b0;
    end else begin
      case (state)
        buck_fault_pkg::ST_OFF: begin
          next_state = buck_fault_pkg::ST_CAL;
          next_cal_cnt = '0;
        end
        buck_fault_pkg::ST_CAL: begin
          next_cal_cnt = cal_cnt + 16'h0001;
          if (cal_cnt >= 16'(CAL_LEN - 1)) begin
            case (res_s)
              buck_fault_pkg::RES_10K: next_mult = buck_fault_pkg::MULT_LOW;
              buck_fault_pkg::RES_20K: next_mult = buck_fault_pkg::MULT_HIGH;
              default: next_mult = buck_fault_pkg::MULT_MID;
            endcase
            next_state = buck_fault_pkg::ST_SS;
            next_boost = 1'b1;
          end
        end
        buck_fault_pkg::ST_SS: begin
          if (ss05_s) begin
            next_boost = 1'b0;
          end
          if (fault) begin
            next_state = buck_fault_pkg::ST_FAULT_DIS;
            next_boost = 1'b0;
          end else if (ss25_s) begin
            next_state = buck_fault_pkg::ST_RUN;
          end
        end
        buck_fault_pkg::ST_RUN: begin
          if (fault) begin
            next_state = buck_fault_pkg::ST_FAULT_DIS;
          end
        end
        buck_fault_pkg::ST_FAULT_DIS: begin
          if (!ss03_s) begin
            next_state = buck_fault_pkg::ST_FAULT_CHG;
          end
        end
        buck_fault_pkg::ST_FAULT_CHG: begin
          if (ss25_s) begin
            next_state = buck_fault_pkg::ST_SS;
          end
        end
        default: next_state = buck_fault_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= buck_fault_pkg::ST_OFF;
      cal_cnt <= '0;
      mult <= buck_fault_pkg::MULT_MID;
      boost <= 1'b0;
    end else begin
      state <= next_state;
      cal_cnt <= next_cal_cnt;
      mult <= next_mult;
      boost <= next_boost;
    end
  end

  // fault counter, trips and gate drives
  always_comb begin
    next_count = count;
    next_fault = fault;
    next_sc_trip = 1'b0;
    next_ol_trip = 1'b0;
    next_lo_pending = lo_pending;
    next_lo_sampled = lo_sampled;
    next_hs_on = hs_on;
    next_ls_on = ls_on;
    next_blank_cnt = blank_cnt;
    if (!run_pwm) begin
      next_hs_on = 1'b0;
      next_ls_on = 1'b0;
      next_blank_cnt = '0;
      next_lo_sampled = 1'b0;
      next_lo_pending = 1'b0;
      // count and flag held only while discharging; recharge starts a fresh attempt
      if (state != buck_fault_pkg::ST_FAULT_DIS) begin
        next_count = buck_fault_pkg::COUNT_MIN;
        next_fault = 1'b0;
      end
    end else begin
      if (cycle_start) begin
        if (lo_sampled && lo_pending && count != buck_fault_pkg::COUNT_MAX) begin
          next_count = count + 3'h1;
        end else if (lo_sampled && !lo_pending && count != buck_fault_pkg::COUNT_MIN) begin
          next_count = count - 3'h1;
        end
        next_lo_sampled = 1'b0;
        next_hs_on = pwm_high_req;
        next_ls_on = !pwm_high_req;
        next_blank_cnt = '0;
      end else begin
        if (hs_on && !pwm_high_req) begin
          next_hs_on = 1'b0;
          next_ls_on = 1'b1;
          next_blank_cnt = '0;
        end else if (blank_cnt < 16'(BLANK_LEN)) begin
          next_blank_cnt = blank_cnt + 16'h0001;
        end
        if (ls_on && blank_cnt >= 16'(BLANK_LEN) && !lo_sampled) begin
          next_lo_pending = ls_over;
          next_lo_sampled = 1'b1;
        end
      end
      if (hs_on && blank_cnt >= 16'(BLANK_LEN) && hs_over) begin
        next_count = buck_fault_pkg::COUNT_MAX;
        next_sc_trip = 1'b1;
        next_hs_on = 1'b0;
      end
      if (next_count == buck_fault_pkg::COUNT_MAX) begin
        next_fault = 1'b1;
        next_ol_trip = !next_sc_trip && !fault;
        next_hs_on = 1'b0;
        next_ls_on = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= buck_fault_pkg::COUNT_MIN;
      fault <= 1'b0;
      sc_trip <= 1'b0;
      ol_trip <= 1'b0;
      lo_pending <= 1'b0;
      lo_sampled <= 1'b0;
      hs_on <= 1'b0;
      ls_on <= 1'b0;
      blank_cnt <= '0;
    end else begin
      count <= next_count;
      fault <= next_fault;
      sc_trip <= next_sc_trip;
      ol_trip <= next_ol_trip;
      lo_pending <= next_lo_pending;
      lo_sampled <= next_lo_sampled;
      hs_on <= next_hs_on;
      ls_on <= next_ls_on;
      blank_cnt <= next_blank_cnt;
    end
  end

  // outputs
  assign high_side_gate_drive = hs_on;
  assign low_side_gate_drive = ls_on;
  assign overcurrent_fault_flag = fault;
  assign overload_trip = ol_trip;
  assign short_circuit_trip = sc_trip;
  assign short_multiplier_code = mult;
  assign fault_count = count;
  assign ss_fast_discharge = !en_s || input_undervoltage_lockout_s || !vbp_ok_s
                             || state == buck_fault_pkg::ST_CAL;
  assign ss_slow_discharge = (state == buck_fault_pkg::ST_FAULT_DIS);
  assign ss_normal_charge = run_pwm || state == buck_fault_pkg::ST_FAULT_CHG;
  assign ss_boost_charge = boost;
  assign ss_ref_enable = run_pwm && ss065_s;
  assign ss_clamp_enable = (state == buck_fault_pkg::ST_RUN);
  assign ss_limit_raised = run_pwm && !ss25_s;
endmodule

//--- pkg/buck_fault_pkg.sv
/*
  constants and state encodings for the buck fault and soft-start logic.
  assumes a single 40 MHz sys_clk; analog comparator results arrive as pins.
*/
package buck_fault_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CAL_TIME_NS = 1000;
  localparam int CAL_CYCLES = (CAL_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BLANK_TIME_NS = 100;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [2:0] COUNT_MAX = 3'h7;
  localparam logic [2:0] COUNT_MIN = 3'h0;
  localparam logic [3:0] MULT_LOW = 4'h3;
  localparam logic [3:0] MULT_MID = 4'h7;
  localparam logic [3:0] MULT_HIGH = 4'hF;
  // resistor sense codes seen on the low-side pin during calibration
  localparam logic [1:0] RES_10K = 2'h0;
  localparam logic [1:0] RES_OPEN = 2'h1;
  localparam logic [1:0] RES_20K = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_CAL = 3'h1,
    ST_SS = 3'h3,
    ST_RUN = 3'h2,
    ST_FAULT_DIS = 3'h6,
    ST_FAULT_CHG = 3'h7
  } seq_state_type;
endpackage

//--- verilog/pin_sync.sv
/*
  three-stage synchroniser for a bundle of asynchronous pin levels.
  assumes inputs are static levels; a change is accepted once stages two and three agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level_out <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level_out <= next_level;
    end
  end
endmodule

//--- tb/buck_fault_monitor.sv
/*
  assertions on the ports of the buck fault and soft-start block.
  assumes one sys_clk domain and the async active-low rst_n.
*/
`timescale 1ns/1ps
module buck_fault_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched pins
  input wire logic input_undervoltage_lockout,
  input wire logic ss_above_0v5,
  input wire logic ss_above_0v65,
  input wire logic ss_above_2v5,
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  input wire logic overcurrent_fault_flag,
  input wire logic short_circuit_trip,
  input wire logic [3:0] short_multiplier_code,
  input wire logic [2:0] fault_count,
  input wire logic ss_fast_discharge,
  input wire logic ss_boost_charge,
  input wire logic ss_ref_enable,
  input wire logic ss_limit_raised
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_fault_gates_off: assert property (
    overcurrent_fault_flag |-> !high_side_gate_drive && !low_side_gate_drive)
    else $error("gate driven while fault flagged");
  a_seven_flags: assert property (
    fault_count == 3'h7 |-> overcurrent_fault_flag)
    else $error("count at seven without fault flag");
  a_count_steps: assert property (
    fault_count != $past(fault_count) |-> fault_count == $past(fault_count) + 3'h1
      || fault_count == $past(fault_count) - 3'h1 || fault_count == 3'h7 || fault_count == 3'h0)
    else $error("count jumped");
  a_short_loads_seven: assert property (
    short_circuit_trip |-> fault_count == 3'h7 && overcurrent_fault_flag && !high_side_gate_drive)
    else $error("short trip without full count or gate off");
  a_mult_legal: assert property (
    short_multiplier_code inside {4'h3, 4'h7, 4'hF})
    else $error("illegal multiplier");
  a_lockout_discharge: assert property (
    input_undervoltage_lockout [*8] |-> ss_fast_discharge)
    else $error("no fast discharge under lockout");
  a_boost_ends: assert property (
    ss_above_0v5 [*8] |-> !ss_boost_charge)
    else $error("boost still on above 0.5 V");
  a_ref_held: assert property (
    !ss_above_0v65 [*8] |-> !ss_ref_enable)
    else $error("reference released below 0.65 V");
  a_limit_normal: assert property (
    ss_above_2v5 [*8] |-> !ss_limit_raised)
    else $error("raised limit above 2.5 V");
  cover property (short_circuit_trip);
  cover property ($rose(overcurrent_fault_flag));
  cover property (ss_boost_charge && !ss_fast_discharge);
endmodule
bind buck_fault_count_softstart buck_fault_monitor mon (.sys_clk, .rst_n,
  .input_undervoltage_lockout, .ss_above_0v5, .ss_above_0v65, .ss_above_2v5,
  .high_side_gate_drive, .low_side_gate_drive, .overcurrent_fault_flag, .short_circuit_trip,
  .short_multiplier_code, .fault_count, .ss_fast_discharge, .ss_boost_charge, .ss_ref_enable,
  .ss_limit_raised);

//--- tb/mosfet_pair_model.sv
/*
  power stage stand-in: turns a load level into comparator results.
  assumes gate drives from the block; a switch that is off reads low.
*/
`timescale 1ns/1ps
module mosfet_pair_model (
  // gate drives
  input wire logic high_side_gate_drive,
  input wire logic low_side_gate_drive,
  // load: 0 light, 1 overload, 2 short
  input wire logic [1:0] load_level,
  // comparator results
  output logic low_over_limit,
  output logic low_over_limit_x15,
  output logic high_over_mult_x3,
  output logic high_over_mult_x7,
  output logic high_over_mult_x15
);
  // drop exists only across a conducting switch
  always_comb begin
    low_over_limit = low_side_gate_drive && (load_level != 2'h0);
    low_over_limit_x15 = low_over_limit;
    high_over_mult_x3 = high_side_gate_drive && (load_level == 2'h2);
    high_over_mult_x7 = high_over_mult_x3;
    high_over_mult_x15 = high_over_mult_x3;
  end
endmodule

//--- tb/buck_fault_count_softstart_test.sv
/*
  testbench for the buck fault and soft-start block.
  assumes a short calibration count and a longer blanking count; pins change on the falling edge.
*/
`timescale 1ns/1ps
module buck_fault_count_softstart_test;
  localparam int CAL = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable_pin = 1'b0;
  logic input_undervoltage_lockout = 1'b1;
  logic gate_supply_rail_ok = 1'b0;
  logic cycle_start = 1'b0;
  logic pwm_high_req = 1'b0;
  logic [1:0] res_sense = 2'h1;
  logic [1:0] load_level = 2'h0;
  logic [3:0] ss_lv = 4'h0;
  logic [4:0] phase = 5'h0;
  logic low_over_limit, low_over_limit_x15, high_over_mult_x3, high_over_mult_x7;
  logic high_over_mult_x15, high_side_gate_drive, low_side_gate_drive, overcurrent_fault_flag;
  logic overload_trip, short_circuit_trip, ss_fast_discharge, ss_slow_discharge;
  logic ss_normal_charge, ss_boost_charge, ss_ref_enable, ss_clamp_enable, ss_limit_raised;
  logic [3:0] short_multiplier_code;
  logic [2:0] fault_count;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  // 24-clock switching cycle, high side asked for the first half
  always @(negedge sys_clk) begin
    phase <= (phase == 5'h17) ? 5'h0 : phase + 5'h1;
    cycle_start <= (phase == 5'h17);
    pwm_high_req <= (phase == 5'h17) || (phase < 5'hB);
  end
  buck_fault_count_softstart #(.CAL_LEN(CAL), .BLANK_LEN(6)) dut (.sys_clk, .rst_n,
    .enable_pin, .input_undervoltage_lockout, .gate_supply_rail_ok, .cycle_start,
    .pwm_high_req, .low_over_limit, .low_over_limit_x15, .high_over_mult_x3,
    .high_over_mult_x7, .high_over_mult_x15, .res_sense, .ss_above_0v3(ss_lv[0]),
    .ss_above_0v5(ss_lv[1]), .ss_above_0v65(ss_lv[2]), .ss_above_2v5(ss_lv[3]),
    .high_side_gate_drive, .low_side_gate_drive, .overcurrent_fault_flag, .overload_trip,
    .short_circuit_trip, .short_multiplier_code, .fault_count, .ss_fast_discharge,
    .ss_slow_discharge, .ss_normal_charge, .ss_boost_charge, .ss_ref_enable,
    .ss_clamp_enable, .ss_limit_raised);
  mosfet_pair_model stage (.high_side_gate_drive, .low_side_gate_drive, .load_level,
    .low_over_limit, .low_over_limit_x15, .high_over_mult_x3, .high_over_mult_x7,
    .high_over_mult_x15);
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic power_up(input logic [1:0] code);
    res_sense = code;
    enable_pin = 1'b1;
    input_undervoltage_lockout = 1'b0;
    gate_supply_rail_ok = 1'b1;
    idle(CAL + 12);
  endtask
  task automatic power_down();
    @(negedge sys_clk);
    enable_pin = 1'b0;
    input_undervoltage_lockout = 1'b1;
    ss_lv = 4'h0;
    load_level = 2'h0;
    idle(10);
    check(ss_fast_discharge, 4'h1);
    check(overcurrent_fault_flag, 4'h0);
  endtask
  task automatic test_calibrate();
    logic [3:0] want [3] = '{4'h3, 4'h7, 4'hF};
    for (int i = 0; i < 3; i++) begin
      power_up(i[1:0]);
      check(short_multiplier_code, want[i]);
      check(ss_fast_discharge, 4'h0);
      check(ss_boost_charge, 4'h1);
      power_down();
    end
    $display("calibration test done");
  endtask
  task automatic test_soft_levels();
    power_up(2'h1);
    ss_lv = 4'h3;
    idle(8);
    check(ss_boost_charge, 4'h0);
    check(ss_ref_enable, 4'h0);
    check(ss_limit_raised, 4'h1);
    ss_lv = 4'h7;
    idle(8);
    check(ss_ref_enable, 4'h1);
    ss_lv = 4'hF;
    idle(8);
    check(ss_limit_raised, 4'h0);
    check(ss_clamp_enable, 4'h1);
    check(ss_normal_charge, 4'h1);
    gate_supply_rail_ok = 1'b0;
    idle(8);
    check(ss_fast_discharge, 4'h1);
    power_down();
    $display("soft-start test done");
  endtask
  task automatic test_overload();
    power_up(2'h1);
    ss_lv = 4'hF;
    load_level = 2'h1;
    for (int i = 0; i < 200 && fault_count !== 3'h3; i++) @(negedge sys_clk);
    check(fault_count, 4'h3);
    load_level = 2'h0;
    idle(200);
    check(fault_count, 4'h0);
    load_level = 2'h1;
    for (int i = 0; i < 400 && overcurrent_fault_flag !== 1'b1; i++) @(negedge sys_clk);
    check(fault_count, 4'h7);
    check({high_side_gate_drive, low_side_gate_drive}, 4'h0);
    check(overload_trip, 4'h1);
    idle(2);
    check(ss_slow_discharge, 4'h1);
    check(ss_normal_charge, 4'h0);
    load_level = 2'h0;
    ss_lv = 4'h0;
    idle(8);
    check(ss_normal_charge, 4'h1);
    check(overcurrent_fault_flag, 4'h0);
    check(fault_count, 4'h0);
    ss_lv = 4'hF;
    idle(8);
    check(ss_clamp_enable, 4'h1);
    power_down();
    $display("overload test done");
  endtask
  task automatic test_short();
    power_up(2'h2);
    ss_lv = 4'hF;
    load_level = 2'h2;
    for (int i = 0; i < 200 && short_circuit_trip !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check(short_circuit_trip, 4'h1);
    check(fault_count, 4'h7);
    check(high_side_gate_drive, 4'h0);
    check(overload_trip, 4'h0);
    power_down();
    $display("short-circuit test done");
  endtask
  // allowance of several times the expected run length
  initial begin
    #250_000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    idle(6);
    check(short_multiplier_code, 4'h7);
    check(ss_fast_discharge, 4'h1);
    test_calibrate();
    test_soft_levels();
    test_overload();
    test_short();
    end_of_test();
  end
endmodule
